// [design/bmam_pkg.sv]
// Shared constants and types for the banked memory address map.
package bmam_pkg;

	localparam int PC_W = 13;
	localparam int PROG_W = 12;
	localparam int FILE_W = 9;

	localparam logic [12:0] RESET_VEC = 13'h0000;
	localparam logic [12:0] IRQ_VEC = 13'h0004;

	localparam logic [6:0] OFF_INDIRECT = 7'h00;
	localparam logic [6:0] OFF_PCL = 7'h02;
	localparam logic [6:0] OFF_STATUS = 7'h03;
	localparam logic [6:0] OFF_POINTER = 7'h04;
	localparam logic [6:0] OFF_PROGRAM_COUNTER_UPPER_LATCH = 7'h0A;
	localparam logic [6:0] OFF_INTCTL = 7'h0B;
	localparam logic [6:0] OFF_GPR_BASE = 7'h20;

	localparam int ST_IRP_BIT = 7;
	localparam int ST_BANK_HI = 6;
	localparam int ST_BANK_LO = 5;

	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] POINTER_RST = 8'h00;
	localparam logic [4:0] PROGRAM_COUNTER_UPPER_LATCH_RST = 5'h00;
	localparam logic [7:0] INTCTL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;

	localparam logic [7:0] GPR_BANK_BYTES = 8'h60;
	localparam int GPR_DEPTH = 192;

	typedef enum logic [1:0]
	{
		BMAM_Q1 = 2'b00,
		BMAM_Q2 = 2'b01,
		BMAM_Q3 = 2'b10,
		BMAM_Q4 = 2'b11
	} bmam_phase_t;

	typedef struct packed
	{
		logic [6:0] file_addr;
		logic [7:0] wdata;
		logic we;
	} bmam_core_req_t;

endpackage : bmam_pkg

// [design/bmam_top.sv]
// Program counter, quarter-cycle sequencing and banked data memory decode.
`timescale 1ns/10ps
// Behaviour
// - Program counter is thirteen bits wide, addressing 8K words.
// - Only 4K program words exist, addresses 0000h to 0FFFh.
// - Program addresses above 0FFFh wrap; only low twelve bits decoded.
// - Reset starts at 0000h; accepted interrupt jumps to 0004h.
// - Status bits 6:5 pick direct-access bank 0 to 3.
// - Banks are 128 bytes; bank bits sit above the seven-bit offset.
// - Low offsets of every bank decode to special function registers.
// - Offsets from 20h upward in banks 0 and 1 are RAM cells.
// - Core control registers decode in every bank.
// - Frequently used control registers answer in more than one bank.
// - Unimplemented locations read zero and ignore writes.
// - File reachable directly or through the indirect address pointer.
// - Operand read in second quarter, destination written in fourth.
module bmam_top
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire bmam_pkg::bmam_core_req_t core_req_in,
	input wire logic branch_in,
	input wire logic [10:0] branch_target_in,
	input wire logic irq_accept_in,
	input wire logic [8:0] bus_addr_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	output logic [7:0] bus_rdata_out,
	output logic [7:0] operand_out,
	output logic [11:0] prog_addr_out,
	output logic [1:0] phase_out,
	output logic [7:0] status_out
);

	bmam_pkg::bmam_phase_t phase_reg;
	bmam_pkg::bmam_phase_t phase_next;
	logic [12:0] pc_reg;
	logic [7:0] status_reg;
	logic [7:0] pointer_reg;
	logic [4:0] program_counter_upper_latch_reg;
	logic [7:0] intctl_reg;
	logic [7:0] gpr_mem [bmam_pkg::GPR_DEPTH];
	logic [8:0] core_addr;
	logic core_wr;
	logic [8:0] w_pcl;
	logic [8:0] w_status;
	logic [8:0] w_pointer;
	logic [8:0] w_program_counter_upper_latch;
	logic [8:0] w_intctl;

	// Control registers ignore the bank bits so they answer in all banks
	function automatic logic [7:0] map_read(input logic [8:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a[6:0] >= bmam_pkg::OFF_GPR_BASE)
		begin
			if (!a[8])
			begin
				v = gpr_mem[gpr_index(a)];
			end
		end
		else
		begin
			case (a[6:0])
				bmam_pkg::OFF_PCL: v = pc_reg[7:0];
				bmam_pkg::OFF_STATUS: v = status_reg;
				bmam_pkg::OFF_POINTER: v = pointer_reg;
				bmam_pkg::OFF_PROGRAM_COUNTER_UPPER_LATCH: v = {3'h0, program_counter_upper_latch_reg};
				bmam_pkg::OFF_INTCTL: v = intctl_reg;
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction : map_read

	function automatic logic [7:0] gpr_index(input logic [8:0] a);
		logic [7:0] base;
		base = a[7] ? bmam_pkg::GPR_BANK_BYTES : 8'h00;
		return base + {1'b0, a[6:0]} - {1'b0, bmam_pkg::OFF_GPR_BASE};
	endfunction : gpr_index

	// Core write wins when both ports hit one register in the same cycle
	function automatic logic [8:0] sfr_wr(input logic [6:0] off);
		logic [8:0] r;
		r = 9'h000;
		if (bus_wr_in && bus_addr_in[6:0] == off)
		begin
			r = {1'b1, bus_wdata_in};
		end
		if (core_wr && core_addr[6:0] == off)
		begin
			r = {1'b1, core_req_in.wdata};
		end
		return r;
	endfunction : sfr_wr

	// Offset zero selects the indirect path through the pointer
	always_comb
	begin
		if (core_req_in.file_addr == bmam_pkg::OFF_INDIRECT)
		begin
			core_addr = {status_reg[bmam_pkg::ST_IRP_BIT], pointer_reg};
		end
		else
		begin
			core_addr = {status_reg[bmam_pkg::ST_BANK_HI:bmam_pkg::ST_BANK_LO],
				core_req_in.file_addr};
		end
	end

	always_comb
	begin
		core_wr = (phase_reg == bmam_pkg::BMAM_Q4) && core_req_in.we;
		w_pcl = sfr_wr(bmam_pkg::OFF_PCL);
		w_status = sfr_wr(bmam_pkg::OFF_STATUS);
		w_pointer = sfr_wr(bmam_pkg::OFF_POINTER);
		w_program_counter_upper_latch = sfr_wr(bmam_pkg::OFF_PROGRAM_COUNTER_UPPER_LATCH);
		w_intctl = sfr_wr(bmam_pkg::OFF_INTCTL);
	end

	always_comb
	begin
		case (phase_reg)
			bmam_pkg::BMAM_Q1: phase_next = bmam_pkg::BMAM_Q2;
			bmam_pkg::BMAM_Q2: phase_next = bmam_pkg::BMAM_Q3;
			bmam_pkg::BMAM_Q3: phase_next = bmam_pkg::BMAM_Q4;
			bmam_pkg::BMAM_Q4: phase_next = bmam_pkg::BMAM_Q1;
			default: phase_next = bmam_pkg::BMAM_Q1;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			phase_reg <= bmam_pkg::BMAM_Q1;
		end
		else
		begin
			phase_reg <= phase_next;
		end
	end

	// Interrupt beats a computed jump, which beats a branch and the fetch step
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pc_reg <= bmam_pkg::RESET_VEC;
		end
		else if (irq_accept_in)
		begin
			pc_reg <= bmam_pkg::IRQ_VEC;
		end
		else if (w_pcl[8])
		begin
			pc_reg <= {program_counter_upper_latch_reg, w_pcl[7:0]};
		end
		else if (branch_in)
		begin
			pc_reg <= {program_counter_upper_latch_reg[4:3], branch_target_in};
		end
		else if (phase_reg == bmam_pkg::BMAM_Q1)
		begin
			pc_reg <= pc_reg + 13'h0001;
		end
	end

	// Upper counter bit is kept but never decoded, so fetch wraps at 0FFFh
	assign prog_addr_out = pc_reg[11:0];

	// Timeout and power-down flags are left to the core's power logic
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			status_reg <= bmam_pkg::STATUS_RST;
		end
		else if (w_status[8])
		begin
			status_reg <= {w_status[7:5], status_reg[4:3], w_status[2:0]};
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pointer_reg <= bmam_pkg::POINTER_RST;
		end
		else if (w_pointer[8])
		begin
			pointer_reg <= w_pointer[7:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			program_counter_upper_latch_reg <= bmam_pkg::PROGRAM_COUNTER_UPPER_LATCH_RST;
		end
		else if (w_program_counter_upper_latch[8])
		begin
			program_counter_upper_latch_reg <= w_program_counter_upper_latch[4:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			intctl_reg <= bmam_pkg::INTCTL_RST;
		end
		else if (w_intctl[8])
		begin
			intctl_reg <= w_intctl[7:0];
		end
	end

	// RAM cells have no reset; only banks 0 and 1 hold storage
	always_ff @(posedge sys_clk_in)
	begin
		if (bus_wr_in && !bus_addr_in[8] && bus_addr_in[6:0] >= bmam_pkg::OFF_GPR_BASE)
		begin
			gpr_mem[gpr_index(bus_addr_in)] <= bus_wdata_in;
		end
		if (core_wr && !core_addr[8] && core_addr[6:0] >= bmam_pkg::OFF_GPR_BASE)
		begin
			gpr_mem[gpr_index(core_addr)] <= core_req_in.wdata;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			operand_out <= bmam_pkg::DATA_RST;
		end
		else if (phase_reg == bmam_pkg::BMAM_Q2)
		begin
			operand_out <= map_read(core_addr);
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			bus_rdata_out <= bmam_pkg::DATA_RST;
		end
		else if (bus_rd_in)
		begin
			bus_rdata_out <= map_read(bus_addr_in);
		end
		else
		begin
			bus_rdata_out <= bmam_pkg::DATA_RST;
		end
	end

	assign phase_out = phase_reg;
	assign status_out = status_reg;

	property p_phase_seq;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		phase_reg == bmam_pkg::BMAM_Q1 |=> phase_reg == bmam_pkg::BMAM_Q2
			##1 phase_reg == bmam_pkg::BMAM_Q3 ##1 phase_reg == bmam_pkg::BMAM_Q4;
	endproperty
	a_phase_seq: assert property (p_phase_seq) else $error("Quarter phases out of order");

	property p_operand_hold;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		phase_reg != bmam_pkg::BMAM_Q2 |=> $stable(operand_out);
	endproperty
	a_operand_hold: assert property (p_operand_hold) else $error("Operand changed outside Q2");

	property p_irq_vec;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		irq_accept_in |=> pc_reg == 13'h0004 && prog_addr_out == 12'h004;
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("Interrupt did not reach vector");

	property p_pc_step;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		phase_reg == bmam_pkg::BMAM_Q1 && !irq_accept_in && !w_pcl[8] && !branch_in
			|=> pc_reg == $past(pc_reg) + 13'h0001
			// A jump taken in the following quarter may legally move the counter again
			##1 ($past(irq_accept_in) || $past(w_pcl[8]) || $past(branch_in) || pc_reg == $past(pc_reg));
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("Counter did not step once");

	property p_wrap;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		phase_reg == bmam_pkg::BMAM_Q1 && pc_reg[11:0] == 12'hFFF && !irq_accept_in
			&& !w_pcl[8] && !branch_in |=> prog_addr_out == 12'h000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Fetch address did not wrap");

	property p_gpr_back;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		bus_wr_in && bus_addr_in == 9'h0A5 && !core_wr ##1 bus_rd_in && bus_addr_in == 9'h0A5
			|=> bus_rdata_out == $past(bus_wdata_in, 2);
	endproperty
	a_gpr_back: assert property (p_gpr_back) else $error("RAM cell lost its value");

	property p_unimpl;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		// Control offsets stay mirrored in banks 2 and 3; only their RAM range is empty
		bus_rd_in && ((bus_addr_in[8] && bus_addr_in[6:0] >= bmam_pkg::OFF_GPR_BASE)
			|| bus_addr_in[6:0] == 7'h01) |=> bus_rdata_out == 8'h00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("Unimplemented read not zero");

	property p_mirror;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		bus_rd_in && bus_addr_in[6:0] == 7'h04 |=> bus_rdata_out == $past(pointer_reg);
	endproperty
	a_mirror: assert property (p_mirror) else $error("Pointer not mirrored");

	property p_status_any_bank;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		bus_rd_in && bus_addr_in[6:0] == 7'h03 |=> bus_rdata_out == $past(status_reg);
	endproperty
	a_status_any_bank: assert property (p_status_any_bank) else $error("Status missing in bank");

	property p_bank_sel;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		phase_reg == bmam_pkg::BMAM_Q2 && core_req_in.file_addr == 7'h21
			&& status_reg[6:5] == 2'b01 |=> operand_out == $past(gpr_mem[97]);
	endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("Bank one not selected");

	property p_indirect;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		phase_reg == bmam_pkg::BMAM_Q2 && core_req_in.file_addr == 7'h00
			&& pointer_reg == 8'h21 && !status_reg[7] |=> operand_out == $past(gpr_mem[1]);
	endproperty
	a_indirect: assert property (p_indirect) else $error("Indirect read wrong cell");

endmodule : bmam_top

// [test/bmam_core_model.sv]
// Behavioural core fetch and execute side: one file access per instruction cycle.
`timescale 1ns/10ps
module bmam_core_model
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [1:0] phase_in,
	input wire bmam_pkg::bmam_core_req_t next_req_in,
	output bmam_pkg::bmam_core_req_t core_req_out
);
	// Requests change only at the instruction boundary so they stand from Q1 through Q4
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			core_req_out <= '0;
		else if (phase_in == bmam_pkg::BMAM_Q4)
			core_req_out <= next_req_in;
	end
endmodule : bmam_core_model

// [test/bmam_top_tb.sv]
// Self-checking bench for the banked memory address map.
`timescale 1ns/10ps
module bmam_top_tb;
	typedef struct packed
	{
		logic [8:0] waddr;
		logic [7:0] wdata;
		logic [8:0] raddr;
		logic [7:0] rexp;
	} bmam_row_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic branch = 1'b0;
	logic irq = 1'b0;
	logic [10:0] target = 11'h000;
	logic [8:0] bus_addr = 9'h000;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_rdata;
	logic [7:0] operand;
	logic [11:0] prog_addr;
	logic [1:0] phase;
	logic [7:0] status;
	bmam_pkg::bmam_core_req_t core_req;
	bmam_pkg::bmam_core_req_t next_req = '0;
	int mismatches = 0;
	int checks = 0;
	// Status writes keep the indirect bank and upper bank bits clear
	// Cell 21h is set before the pointer aims at it, since RAM has no reset and idle reads go indirect
	bmam_row_t rows [15] = '{'{9'h0A5, 8'h5A, 9'h0A5, 8'h5A}, '{9'h020, 8'h11, 9'h020, 8'h11},
		'{9'h0FF, 8'hEE, 9'h0FF, 8'hEE}, '{9'h07F, 8'h77, 9'h07F, 8'h77}, '{9'h120, 8'h99, 9'h120, 8'h00},
		'{9'h1A0, 8'h99, 9'h1A0, 8'h00}, '{9'h001, 8'h55, 9'h001, 8'h00}, '{9'h01F, 8'h55, 9'h01F, 8'h00},
		'{9'h09F, 8'h55, 9'h09F, 8'h00}, '{9'h000, 8'h55, 9'h000, 8'h00}, '{9'h021, 8'h00, 9'h021, 8'h00},
		'{9'h084, 8'h21, 9'h004, 8'h21},
		'{9'h08B, 8'hA5, 9'h10B, 8'hA5}, '{9'h003, 8'h07, 9'h183, 8'h1F}, '{9'h18A, 8'hEF, 9'h00A, 8'h0F}};

	always #12.5 sys_clk = ~sys_clk;

	bmam_core_model PARTNER
	(
		.sys_clk_in(sys_clk),
		.rst_n_in(rst_n),
		.phase_in(phase),
		.next_req_in(next_req),
		.core_req_out(core_req)
	);

	bmam_top DUT
	(
		.sys_clk_in(sys_clk),
		.rst_n_in(rst_n),
		.core_req_in(core_req),
		.branch_in(branch),
		.branch_target_in(target),
		.irq_accept_in(irq),
		.bus_addr_in(bus_addr),
		.bus_wdata_in(bus_wdata),
		.bus_wr_in(bus_wr),
		.bus_rd_in(bus_rd),
		.bus_rdata_out(bus_rdata),
		.operand_out(operand),
		.prog_addr_out(prog_addr),
		.phase_out(phase),
		.status_out(status)
	);

	task check(input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task conclude;
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	task bus_write(input logic [8:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask : bus_write

	task bus_read(input logic [8:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		check(12'(bus_rdata), 12'(exp));
	endtask : bus_read

	// Operand is only meaningful for reads; a write's old cell may be uninitialised
	task core_op(input logic [6:0] a, input logic [7:0] d, input logic we, input logic [7:0] exp);
		@(posedge sys_clk);
		next_req <= {a, d, we};
		#1;
		while (phase !== bmam_pkg::BMAM_Q4)
		begin
			@(posedge sys_clk);
			#1;
		end
		repeat (3) @(posedge sys_clk);
		#1;
		if (!we)
			check(12'(operand), 12'(exp));
		@(posedge sys_clk);
		next_req <= '0;
	endtask : core_op

	task do_reset;
		@(posedge sys_clk);
		rst_n <= 1'b0;
		#1;
		check(prog_addr, 12'h000);
		check(12'(status), 12'h018);
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		check(prog_addr, 12'h001);
		check(12'(phase), 12'h001);
		repeat (4) @(posedge sys_clk);
		#1;
		check(prog_addr, 12'h002);
	endtask : do_reset

	initial
	begin
		#(25 * 3000);
		mismatches++;
		conclude();
	end

	initial
	begin
		do_reset();
		foreach (rows[i])
		begin
			bus_write(rows[i].waddr, rows[i].wdata);
			bus_read(rows[i].raddr, rows[i].rexp);
		end
		// Write and read with no gap between the strobes
		@(posedge sys_clk);
		bus_wr <= 1'b1;
		bus_addr <= 9'h0A5;
		bus_wdata <= 8'hC6;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		check(12'(bus_rdata), 12'h0C6);
		core_op(7'h21, 8'h3C, 1'b1, 8'h00);
		core_op(7'h21, 8'h00, 1'b0, 8'h3C);
		core_op(7'h00, 8'h00, 1'b0, 8'h3C);
		core_op(7'h00, 8'h4D, 1'b1, 8'h00);
		bus_read(9'h021, 8'h4D);
		bus_write(9'h0A1, 8'hC3);
		bus_write(9'h003, 8'h20);
		bus_read(9'h003, 8'h38);
		core_op(7'h21, 8'h00, 1'b0, 8'hC3);
		bus_write(9'h003, 8'h00);
		// Computed jump through the low counter byte in bank 1, upper bits from the latch
		bus_write(9'h082, 8'h34);
		#1;
		check(prog_addr, 12'hF34);
		@(posedge sys_clk);
		branch <= 1'b1;
		target <= 11'h7FF;
		@(posedge sys_clk);
		branch <= 1'b0;
		#1;
		check(prog_addr, 12'hFFF);
		repeat (4) @(posedge sys_clk);
		#1;
		check(prog_addr, 12'h000);
		@(posedge sys_clk);
		irq <= 1'b1;
		branch <= 1'b1;
		@(posedge sys_clk);
		irq <= 1'b0;
		branch <= 1'b0;
		#1;
		check(prog_addr, 12'h004);
		do_reset();
		bus_read(9'h004, 8'h00);
		bus_read(9'h08A, 8'h00);
		conclude();
	end
endmodule : bmam_top_tb
